// ==== rls_defines.vh ====
// register offsets, field positions, reset values and timing counts
// assumes inclusion by every file of the loop-side start-up sequencer
`ifndef RLS_DEFINES_VH
`define RLS_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define RLS_OFS_CTRL 8'h00
`define RLS_OFS_STATUS 8'h04
`define RLS_OFS_IRQ_STAT 8'h08
`define RLS_OFS_IRQ_MASK 8'h0C
`define RLS_OFS_OWN_CAPS 8'h10
`define RLS_OFS_CAPS_SENT 8'h14
`define RLS_OFS_MODE 8'h18
`define RLS_OFS_DIAG_MODE 8'h1C

// ****************************************
// field positions
// ****************************************
`define RLS_CTRL_EN 0
`define RLS_CTRL_LAUNCH 1
`define RLS_CTRL_ADDR_LO 4
`define RLS_CTRL_ADDR_HI 6
`define RLS_ADDR_W 3
`define RLS_IRQ_W 4
`define RLS_IRQ_ACTIVE 0
`define RLS_IRQ_LINK_FAIL 1
`define RLS_IRQ_HS_TIMEOUT 2
`define RLS_IRQ_SEG_FAIL 3

// ****************************************
// reset values
// ****************************************
`define RLS_RST_EN 1'b0
`define RLS_RST_ADDR 3'h0
`define RLS_RST_MASK 4'h0

// ****************************************
// timing
// ****************************************
`define RLS_CNT_W 40
`define RLS_CLK_HZ 40'd250000000
`define RLS_GUARD_TIME_S 40'd240
`define RLS_HS_TIME_S 40'd30
`define RLS_GUARD_CYCLES (`RLS_GUARD_TIME_S * `RLS_CLK_HZ)
`define RLS_HS_CYCLES (`RLS_HS_TIME_S * `RLS_CLK_HZ)

`endif

// ==== rls_timer.v ====
// up-counting timeout timer with a sticky expiry level
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`include "rls_defines.vh"

module rls_timer #(
  parameter CNT_W = `RLS_CNT_W,
  parameter [CNT_W-1:0] LIMIT = `RLS_GUARD_CYCLES
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire clear_in,
  input wire run_in,
  output reg expired_out
);

  reg [CNT_W-1:0] count_q;

  // ****************************************
  // counter
  // ****************************************
  // holds its count while run is low, so a stopped timer keeps its value
  always @(posedge sys_clk_in) begin
    if (srst_in || clear_in) begin
      count_q <= {CNT_W{1'b0}};
      expired_out <= 1'b0;
    end else if (run_in && !expired_out) begin
      if (count_q == LIMIT - 1'b1) begin
        expired_out <= 1'b1;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

endmodule // rls_timer

// ==== rls_cap_isect.v ====
// capability list sent to the office-side half
// assumes the inputs are stable in the cycle of load_in
`timescale 1ns/100ps
`include "rls_defines.vh"

module rls_cap_isect #(
  parameter CAP_W = 16
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire load_in,
  input wire [CAP_W-1:0] own_caps_in,
  input wire [CAP_W-1:0] rx_caps_in,
  input wire probe_used_in,
  input wire [CAP_W-1:0] probe_caps_in,
  output reg [CAP_W-1:0] caps_out
);

  wire [CAP_W-1:0] probe_term;

  // ****************************************
  // intersection
  // ****************************************
  // an unused probe must not narrow the list
  assign probe_term = probe_used_in ? probe_caps_in : {CAP_W{1'b1}};

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      caps_out <= {CAP_W{1'b0}};
    end else if (load_in) begin
      caps_out <= own_caps_in & rx_caps_in & probe_term;
    end
  end

endmodule // rls_cap_isect

// ==== rls_loop_fsm.v ====
// start-up sequencer of the loop-facing regenerator half, with apb registers
// assumes a handshake engine on the loop side and the office-side half on
// the internal interface, all synchronous to sys_clk_in
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "rls_defines.vh"

// How it works
// - remote-launched start goes idle to wait
// - office-launched start goes idle to session one
// - regenerator launch treated like office launch
// - entering wait raises caps available, sends list
// - sent list is own, received, probe intersection
// - capture office mode with its active indication
// - second session uses exactly the captured mode
// - start-up guard timer lasts four minutes
// - guard expiry before active: idle, link failure
// - handshake not done in 30 s: fail, idle
// - diag bit plus later failure: act office-end
// - diag failure in wait: pick mode, session two
// - status exchanged over dedicated internal connection
// - regenerator address covers eight per span
// - segment failure returns to idle
module rls_loop_fsm #(
  parameter CAP_W = 16,
  parameter MODE_W = 8,
  parameter [`RLS_CNT_W-1:0] GUARD_CYCLES = `RLS_GUARD_CYCLES,
  parameter [`RLS_CNT_W-1:0] HS_CYCLES = `RLS_HS_CYCLES
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  output wire irq_out,
  input wire start_remote_in,
  input wire start_office_in,
  input wire hs_ok_in,
  input wire [CAP_W-1:0] hs_rx_caps_in,
  input wire diag_bit_in,
  input wire probe_used_in,
  input wire [CAP_W-1:0] probe_caps_in,
  input wire seg_fail_in,
  output reg hs_start_out,
  output reg [MODE_W-1:0] hs_mode_out,
  output reg office_role_out,
  input wire office_active_in,
  input wire [MODE_W-1:0] office_mode_in,
  input wire office_fail_in,
  output reg caps_avail_out,
  output wire [CAP_W-1:0] caps_list_out,
  output reg link_fail_out,
  output reg [2:0] state_out,
  output reg [`RLS_ADDR_W-1:0] regen_addr_out
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_HS1 = 3'h2;
  localparam [2:0] ST_HS2 = 3'h3;
  localparam [2:0] ST_ACT = 3'h4;

  reg en_q;
  reg launch_q;
  reg diag_q;
  reg [`RLS_IRQ_W-1:0] irq_stat_q;
  reg [`RLS_IRQ_W-1:0] irq_mask_q;
  reg [CAP_W-1:0] own_caps_q;
  reg [MODE_W-1:0] diag_mode_q;
  reg [2:0] state_d;
  reg hs_start_d;
  reg fail_d;
  reg hs_to_d;
  reg seg_d;
  reg take_office_d;
  reg take_diag_d;
  reg [31:0] rdata_d;
  reg mapped_d;
  reg [`RLS_IRQ_W-1:0] irq_set_d;
  wire access;
  wire wr_en;
  wire guard_exp;
  wire hs_exp;
  wire guard_run;
  wire guard_clr;
  wire hs_run;
  wire hs_clr;
  wire enter_wait;

  // ****************************************
  // apb slave
  // ****************************************
  // zero wait states; read data is latched in the setup cycle
  assign access = psel_in && penable_in;
  assign wr_en = access && pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !mapped_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    mapped_d = 1'b1;
    case (paddr_in)
      `RLS_OFS_CTRL: begin
        rdata_d[`RLS_CTRL_EN] = en_q;
        rdata_d[`RLS_CTRL_ADDR_HI:`RLS_CTRL_ADDR_LO] = regen_addr_out;
      end
      `RLS_OFS_STATUS: begin
        rdata_d[2:0] = state_out;
        rdata_d[4] = office_role_out;
        rdata_d[5] = diag_q;
        rdata_d[6] = caps_avail_out;
      end
      `RLS_OFS_IRQ_STAT: rdata_d[`RLS_IRQ_W-1:0] = irq_stat_q;
      `RLS_OFS_IRQ_MASK: rdata_d[`RLS_IRQ_W-1:0] = irq_mask_q;
      `RLS_OFS_OWN_CAPS: rdata_d[CAP_W-1:0] = own_caps_q;
      `RLS_OFS_CAPS_SENT: rdata_d[CAP_W-1:0] = caps_list_out;
      `RLS_OFS_MODE: rdata_d[MODE_W-1:0] = hs_mode_out;
      `RLS_OFS_DIAG_MODE: rdata_d[MODE_W-1:0] = diag_mode_q;
      default: mapped_d = 1'b0;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      prdata_out <= 32'h0000_0000;
      en_q <= `RLS_RST_EN;
      launch_q <= 1'b0;
      regen_addr_out <= `RLS_RST_ADDR;
      irq_mask_q <= `RLS_RST_MASK;
      own_caps_q <= {CAP_W{1'b1}};
      diag_mode_q <= {MODE_W{1'b0}};
    end else begin
      launch_q <= 1'b0;
      if (psel_in && !penable_in) begin
        prdata_out <= rdata_d;
      end
      if (wr_en) begin
        case (paddr_in)
          `RLS_OFS_CTRL: begin
            en_q <= pwdata_in[`RLS_CTRL_EN];
            launch_q <= pwdata_in[`RLS_CTRL_LAUNCH];
            // 3 bits: one address per regenerator, eight in a span
            regen_addr_out <= pwdata_in[`RLS_CTRL_ADDR_HI:`RLS_CTRL_ADDR_LO];
          end
          `RLS_OFS_IRQ_MASK: irq_mask_q <= pwdata_in[`RLS_IRQ_W-1:0];
          `RLS_OFS_OWN_CAPS: own_caps_q <= pwdata_in[CAP_W-1:0];
          `RLS_OFS_DIAG_MODE: diag_mode_q <= pwdata_in[MODE_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // timers
  // ****************************************
  assign guard_run = (state_out != ST_IDLE) && (state_out != ST_ACT);
  assign guard_clr = (state_out == ST_IDLE);
  assign hs_run = (state_out == ST_HS1) || (state_out == ST_HS2);
  assign hs_clr = hs_start_out || !hs_run;

  rls_timer #(
    .CNT_W(`RLS_CNT_W),
    .LIMIT(GUARD_CYCLES)
  ) u_guard (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clear_in(guard_clr),
    .run_in(guard_run),
    .expired_out(guard_exp)
  );

  rls_timer #(
    .CNT_W(`RLS_CNT_W),
    .LIMIT(HS_CYCLES)
  ) u_hs (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .clear_in(hs_clr),
    .run_in(hs_run),
    .expired_out(hs_exp)
  );

  // ****************************************
  // start-up sequence
  // ****************************************
  // outside idle, segment failure outranks every other event in the same cycle
  always @* begin
    state_d = state_out;
    hs_start_d = 1'b0;
    fail_d = 1'b0;
    hs_to_d = 1'b0;
    seg_d = 1'b0;
    take_office_d = 1'b0;
    take_diag_d = 1'b0;
    if (seg_fail_in && (state_out != ST_IDLE)) begin
      state_d = ST_IDLE;
      fail_d = 1'b1;
      seg_d = 1'b1;
    end else begin
      case (state_out)
        ST_IDLE: begin
          if (en_q && (start_office_in || launch_q)) begin
            state_d = ST_HS1;
            hs_start_d = 1'b1;
          end else if (en_q && start_remote_in) begin
            state_d = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (guard_exp) begin
            state_d = ST_IDLE;
            fail_d = 1'b1;
          end else if (office_active_in) begin
            state_d = ST_HS2;
            take_office_d = 1'b1;
            hs_start_d = 1'b1;
          end else if (office_fail_in && diag_q) begin
            state_d = ST_HS2;
            take_diag_d = 1'b1;
            hs_start_d = 1'b1;
          end else if (office_fail_in) begin
            state_d = ST_IDLE;
          end
        end
        ST_HS1, ST_HS2: begin
          if (guard_exp) begin
            state_d = ST_IDLE;
            fail_d = 1'b1;
          end else if (hs_exp) begin
            state_d = ST_IDLE;
            fail_d = 1'b1;
            hs_to_d = 1'b1;
          end else if (hs_ok_in) begin
            state_d = (state_out == ST_HS1) ? ST_WAIT : ST_ACT;
          end
        end
        ST_ACT: state_d = ST_ACT;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  assign enter_wait = (state_d == ST_WAIT) && (state_out != ST_WAIT);

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_out <= ST_IDLE;
      hs_start_out <= 1'b0;
      link_fail_out <= 1'b0;
      caps_avail_out <= 1'b0;
      hs_mode_out <= {MODE_W{1'b0}};
      office_role_out <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      state_out <= state_d;
      hs_start_out <= hs_start_d;
      link_fail_out <= fail_d;
      caps_avail_out <= (state_d == ST_WAIT);
      if (enter_wait) begin
        diag_q <= diag_bit_in;
      end else if (state_d == ST_IDLE) begin
        diag_q <= 1'b0;
      end
      if (take_office_d) begin
        hs_mode_out <= office_mode_in;
      end else if (take_diag_d) begin
        hs_mode_out <= diag_mode_q;
      end
      if (take_diag_d) begin
        office_role_out <= 1'b1;
      end else if (state_d == ST_IDLE) begin
        office_role_out <= 1'b0;
      end
    end
  end

  rls_cap_isect #(
    .CAP_W(CAP_W)
  ) u_caps (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .load_in(enter_wait),
    .own_caps_in(own_caps_q),
    .rx_caps_in(hs_rx_caps_in),
    .probe_used_in(probe_used_in),
    .probe_caps_in(probe_caps_in),
    .caps_out(caps_list_out)
  );

  // ****************************************
  // interrupts
  // ****************************************
  always @* begin
    irq_set_d = {`RLS_IRQ_W{1'b0}};
    irq_set_d[`RLS_IRQ_ACTIVE] = (state_d == ST_ACT) && (state_out != ST_ACT);
    irq_set_d[`RLS_IRQ_LINK_FAIL] = fail_d;
    irq_set_d[`RLS_IRQ_HS_TIMEOUT] = hs_to_d;
    irq_set_d[`RLS_IRQ_SEG_FAIL] = seg_d;
  end

  // a new event in the clearing cycle survives the write of one
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq_stat_q <= {`RLS_IRQ_W{1'b0}};
    end else if (wr_en && (paddr_in == `RLS_OFS_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~pwdata_in[`RLS_IRQ_W-1:0]) | irq_set_d;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set_d;
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule // rls_loop_fsm

// ==== rls_loop_fsm_properties.sv ====
// port assertions for the loop-side start-up sequencer
// assumes bind onto rls_loop_fsm, one clock, sync reset
`timescale 1ns/100ps
module rls_loop_fsm_properties #(
  parameter MODE_W = 8
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire start_remote_in,
  input wire start_office_in,
  input wire seg_fail_in,
  input wire hs_start_out,
  input wire [MODE_W-1:0] hs_mode_out,
  input wire office_role_out,
  input wire office_active_in,
  input wire [MODE_W-1:0] office_mode_in,
  input wire office_fail_in,
  input wire caps_avail_out,
  input wire link_fail_out,
  input wire [2:0] state_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);
  // ****************
  // sequencing
  // ****************
  property p_rem;
    state_out == 3'd0 ##1 state_out == 3'd1
      |-> $past(start_remote_in) && !$past(start_office_in);
  endproperty
  a_rem: assert property (p_rem)
    else $error("wait entered without remote start");
  property p_off;
    state_out == 3'd0 && start_office_in |=> state_out inside {3'd0, 3'd2};
  endproperty
  a_off: assert property (p_off)
    else $error("office start went astray");
  property p_caps;
    caps_avail_out == (state_out == 3'd1);
  endproperty
  a_caps: assert property (p_caps)
    else $error("caps available out of wait");
  property p_mode;
    state_out == 3'd1 && office_active_in && !seg_fail_in |=> state_out == 3'd0
      || (state_out == 3'd3 && hs_start_out && hs_mode_out == $past(office_mode_in));
  endproperty
  a_mode: assert property (p_mode)
    else $error("office mode not taken");
  property p_diag;
    state_out == 3'd1 && office_fail_in && !office_active_in && !seg_fail_in
      |=> state_out == 3'd0 || (state_out == 3'd3 && office_role_out && hs_start_out);
  endproperty
  a_diag: assert property (p_diag)
    else $error("diag stand-in wrong");
  property p_seg;
    state_out != 3'd0 && seg_fail_in |=> state_out == 3'd0 && link_fail_out;
  endproperty
  a_seg: assert property (p_seg)
    else $error("segment failure not handled");
  property p_fail;
    link_fail_out |-> state_out == 3'd0 ##1 !link_fail_out;
  endproperty
  a_fail: assert property (p_fail)
    else $error("link failure pulse wrong");
  property p_hs;
    hs_start_out |-> state_out != $past(state_out) && state_out inside {3'd2, 3'd3};
  endproperty
  a_hs: assert property (p_hs)
    else $error("handshake start outside session entry");
endmodule // rls_loop_fsm_properties
bind rls_loop_fsm rls_loop_fsm_properties #(.MODE_W(MODE_W)) u_props (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .start_remote_in(start_remote_in),
  .start_office_in(start_office_in), .seg_fail_in(seg_fail_in),
  .hs_start_out(hs_start_out), .hs_mode_out(hs_mode_out),
  .office_role_out(office_role_out), .office_active_in(office_active_in),
  .office_mode_in(office_mode_in), .office_fail_in(office_fail_in),
  .caps_avail_out(caps_avail_out), .link_fail_out(link_fail_out),
  .state_out(state_out));

// ==== rls_office_model.sv ====
// behavioural office-side half facing the sequencer
// assumes the bench sets delay, mode and failure choice
`timescale 1ns/100ps
module rls_office_model (
  input wire sys_clk_in,
  input wire srst_in,
  input wire caps_avail_in,
  input wire [7:0] delay_in,
  input wire fail_in,
  input wire [7:0] mode_in,
  output reg active_out,
  output reg fail_out,
  output reg [7:0] mode_out
);
  // ****************
  // answer after delay
  // ****************
  reg [7:0] cnt_q;
  always @(posedge sys_clk_in) begin
    active_out <= 1'b0;
    fail_out <= 1'b0;
    mode_out <= ~mode_out; // released, never stale
    if (srst_in) begin
      mode_out <= 8'h00;
      cnt_q <= 8'h00;
    end else if (!caps_avail_in) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == delay_in && fail_in) begin
        fail_out <= 1'b1;
      end else if (cnt_q == delay_in) begin
        active_out <= 1'b1;
        mode_out <= mode_in;
      end
    end
  end
endmodule // rls_office_model

// ==== regen_loop_side_startup_fsm_bench.sv ====
// self-checking bench for the loop-side start-up sequencer
// assumes rls_office_model as the office-side half
`timescale 1ns/100ps
`include "rls_defines.vh"
module regen_loop_side_startup_fsm_bench;
  logic clk, rst, psel, pen, pwr, se, diag, pu, pfail;
  logic [3:0] pv;
  logic [7:0] pa, pmode, pdly;
  logic [31:0] pwd, rd, rnd;
  logic [15:0] rxc, pc, own;
  wire rdy, err, irq, hs_start, role, act, ofail, cav, lfail;
  wire [7:0] hs_mode, omode;
  wire [31:0] prd;
  wire [15:0] clist;
  wire [2:0] state, raddr;
  int err_count = 0, n_checks = 0, nfail = 0, efail = 0, n, i;
  time t0;
  rls_loop_fsm #(.GUARD_CYCLES(40'd200), .HS_CYCLES(40'd50)) rls_loop_fsm_inst (
    .sys_clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .irq_out(irq), .start_remote_in(pv[2]), .start_office_in(pv[3]),
    .hs_ok_in(pv[1]), .hs_rx_caps_in(rxc), .diag_bit_in(diag), .probe_used_in(pu),
    .probe_caps_in(pc), .seg_fail_in(pv[0]), .hs_start_out(hs_start),
    .hs_mode_out(hs_mode), .office_role_out(role), .office_active_in(act),
    .office_mode_in(omode), .office_fail_in(ofail), .caps_avail_out(cav),
    .caps_list_out(clist), .link_fail_out(lfail), .state_out(state),
    .regen_addr_out(raddr));
  rls_office_model rls_office_model_inst (.sys_clk_in(clk), .srst_in(rst),
    .caps_avail_in(cav), .delay_in(pdly), .fail_in(pfail), .mode_in(pmode),
    .active_out(act), .fail_out(ofail), .mode_out(omode));
  // ****************
  // clock, tasks
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (lfail === 1'b1) nfail <= nfail + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    se = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task pl(input logic [3:0] v);
    @(posedge clk);
    pv <= v;
    @(posedge clk);
    pv <= 4'h0;
  endtask
  // waits for a state, n counts the cycles
  task wst(input logic [2:0] s);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (state !== s && n < 400);
    chk(state, s);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    conclude;
  end
  initial begin
    {rst, psel, pen, pwr, diag, pu, pfail} = 7'h40;
    {pv, pa, pmode, pdly, pwd, rxc, pc} = 0;
    rnd = 32'h42582190;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(0, `RLS_OFS_OWN_CAPS, 0);
    chk(rd, 32'h0000FFFF);
    apb(0, 8'h40, 32'hFFFFFFFF);
    chk(se, 1'b1);
    chk(rd, 32'h00000000);
    apb(1, `RLS_OFS_CTRL, 32'h51);
    apb(1, `RLS_OFS_IRQ_MASK, 32'hF);
    rnd = lfsr(rnd);
    own = rnd[15:0];
    apb(1, `RLS_OFS_OWN_CAPS, {16'h0, own});
    chk(raddr, 3'h5);
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      {rxc, pc, pu, pmode, pdly} <= {rnd, i[0], rnd[7:0] ^ rnd[23:16], 8'h05};
      pl(4'h4);
      wst(3'd1);
      chk(cav, 1'b1);
      chk(clist, own & rnd[31:16] & (i ? rnd[15:0] : 16'hFFFF));
      wst(3'd3);
      chk({hs_start, hs_mode}, {1'b1, pmode});
      pl(4'h2);
      wst(3'd4);
      chk(irq, 1'b1);
      apb(1, `RLS_OFS_IRQ_STAT, 32'h1);
      #1;
      chk(irq, 1'b0);
      pl(4'h1);
      wst(3'd0);
      efail++;
      apb(0, `RLS_OFS_IRQ_STAT, 0);
      chk(rd[3], 1'b1);
      apb(1, `RLS_OFS_IRQ_STAT, 32'hF);
    end
    pl(4'hC);
    wst(3'd2);
    wst(3'd0);
    chk(n >= 48 && n <= 54, 1'b1);
    efail++;
    apb(0, `RLS_OFS_IRQ_STAT, 0);
    chk(rd[2], 1'b1);
    apb(1, `RLS_OFS_IRQ_STAT, 32'hF);
    pdly <= 8'hFF;
    apb(1, `RLS_OFS_CTRL, 32'h53);
    t0 = $time;
    wst(3'd2);
    pl(4'h2);
    wst(3'd1);
    wst(3'd0);
    chk(($time - t0) / 4 inside {[199:205]}, 1'b1);
    efail++;
    apb(0, `RLS_OFS_CTRL, 0);
    chk(rd, 32'h51);
    apb(0, `RLS_OFS_IRQ_STAT, 0);
    chk(rd[1], 1'b1);
    rnd = lfsr(rnd);
    apb(1, `RLS_OFS_DIAG_MODE, {24'h0, rnd[7:0]});
    {diag, pfail, pdly} <= {2'b11, 8'h03};
    pl(4'h4);
    wst(3'd3);
    chk({role, hs_mode}, {1'b1, rnd[7:0]});
    apb(0, `RLS_OFS_STATUS, 0);
    chk(rd, 32'h00000033);
    pl(4'h1);
    wst(3'd0);
    efail++;
    @(posedge clk);
    diag <= 1'b0;
    pl(4'h4);
    wst(3'd1);
    wst(3'd0);
    chk(role, 1'b0);
    apb(0, `RLS_OFS_MODE, 0);
    chk(rd, {24'h0, rnd[7:0]});
    chk(nfail, efail);
    conclude;
  end
endmodule // regen_loop_side_startup_fsm_bench
